/* logic/tdpm_regs.vh */
// Register map and field constants for the test-reset and decoder pin mux
`ifndef TDPM_REGS_VH
`define TDPM_REGS_VH

// ***************************************************************
// Register byte offsets (one aligned 32-bit word each)
// ***************************************************************
`define TDPM_OFF_PUDR      5'h00
`define TDPM_OFF_PUR       5'h04
`define TDPM_OFF_SEL       5'h08
`define TDPM_OFF_GPIO_DIR  5'h0C
`define TDPM_OFF_GPIO_OUT  5'h10
`define TDPM_OFF_STATUS    5'h14
`define TDPM_ADDR_W        5

// ***************************************************************
// Field positions
// ***************************************************************
`define TDPM_PUDR_TEST_BIT 0
`define TDPM_PUR_A_BIT     4
`define TDPM_PUR_B_BIT     5
`define TDPM_SEL_W         2
`define TDPM_SEL_A_LSB     0
`define TDPM_SEL_B_LSB     2
`define TDPM_GPIO_A_BIT    0
`define TDPM_GPIO_B_BIT    1

// ***************************************************************
// Pin function codes and reset values
// ***************************************************************
`define TDPM_FN_DECODER    2'h0
`define TDPM_FN_TIMER      2'h1
`define TDPM_FN_GPIO       2'h2
`define TDPM_PUDR_RST      1'h0
`define TDPM_PUR_RST       8'hFF
`define TDPM_SEL_RST       4'h0
`define TDPM_GPIO_RST      2'h0

`endif

/* logic/tdpm_pin_mux.v */
// Pin mux for test reset and the two quadrature phase pins, Wishbone slave
// Functional notes
// - Low level on test reset input resets the test access port controller.
// - Setting test-port pull-up disable bit turns off test reset pull-up.
// - After reset, first shared pin selects decoder phase A.
// - Clearing port C pull-up bit 4 disables phase A pin pull-up.
// - After reset, second shared pin selects decoder phase B.
// - Clearing port C pull-up bit 5 disables phase B pin pull-up.
// - In GPIO use each pin is independently an input or output.
`timescale 1ns/10ps
`include "tdpm_regs.vh"

module tdpm_pin_mux (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        clk_en,
	// Wishbone classic slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	// Test reset pin
	input  wire        test_rst_n_pin,
	output reg         test_rst_n,
	output reg         test_rst_pullup_en,
	// Shared pin A
	input  wire        pin_a_in,
	output reg         pin_a_out,
	output reg         pin_a_oe,
	output reg         pin_a_pullup_en,
	// Shared pin B
	input  wire        pin_b_in,
	output reg         pin_b_out,
	output reg         pin_b_oe,
	output reg         pin_b_pullup_en,
	// Function side
	output reg         decoder_phase_a_in,
	output reg         decoder_phase_b_in,
	input  wire        timer_ch0_out,
	input  wire        timer_ch0_oe,
	output reg         timer_ch0_in,
	input  wire        timer_ch1_out,
	input  wire        timer_ch1_oe,
	output reg         timer_ch1_in,
	output reg  [1:0]  port_c_in
);

	// ***************************************************************
	// Registers
	// ***************************************************************
	reg        pudr_reg;
	reg  [7:0] pur_reg;
	reg  [3:0] sel_reg;
	reg  [1:0] dir_reg;
	reg  [1:0] gout_reg;
	reg  [1:0] trst_sync_reg;
	reg        test_rst_pullup_next;
	reg        pin_a_pullup_next;
	reg        pin_b_pullup_next;
	reg        dec_a_next;
	reg        dec_b_next;
	reg        tmr0_in_next;
	reg        tmr1_in_next;
	reg  [1:0] gpio_in_next;
	reg        a_out_next;
	reg        a_oe_next;
	reg        b_out_next;
	reg        b_oe_next;
	reg  [1:0] a_sync_reg;
	reg  [1:0] b_sync_reg;
	reg  [31:0] rdata_next;
	reg         hit;

	wire        req;
	wire        wr_lo;
	wire [`TDPM_ADDR_W-1:0] adr;
	wire [1:0]  sel_a;
	wire [1:0]  sel_b;
	wire        trst_s;
	wire        a_s;
	wire        b_s;

	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr_lo = req & wb_we_i & wb_sel_i[0];
	assign adr   = wb_adr_i[`TDPM_ADDR_W-1:0];
	assign sel_a = sel_reg[`TDPM_SEL_A_LSB +: `TDPM_SEL_W];
	assign sel_b = sel_reg[`TDPM_SEL_B_LSB +: `TDPM_SEL_W];
	assign trst_s = trst_sync_reg[1];
	assign a_s    = a_sync_reg[1];
	assign b_s    = b_sync_reg[1];

	// ***************************************************************
	// Address decode and read mux
	// ***************************************************************
	// Unmapped or misaligned addresses answer with err
	always @* begin
		rdata_next = 32'h0000_0000;
		hit        = (wb_adr_i[31:`TDPM_ADDR_W] ==
			{(32-`TDPM_ADDR_W){1'b0}});
		case (adr)
		`TDPM_OFF_PUDR:
			rdata_next[`TDPM_PUDR_TEST_BIT] = pudr_reg;
		`TDPM_OFF_PUR:
			rdata_next[7:0] = pur_reg;
		`TDPM_OFF_SEL:
			rdata_next[3:0] = sel_reg;
		`TDPM_OFF_GPIO_DIR:
			rdata_next[1:0] = dir_reg;
		`TDPM_OFF_GPIO_OUT:
			rdata_next[1:0] = gout_reg;
		`TDPM_OFF_STATUS:
			rdata_next[2:0] = {trst_s, b_s, a_s};
		default:
			hit = 1'b0;
		endcase
	end

	// ***************************************************************
	// Bus answer and register writes
	// ***************************************************************
	// One-cycle ack after the request is seen; writes land at that edge
	always @(posedge mclk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			pudr_reg <= `TDPM_PUDR_RST;
			pur_reg  <= `TDPM_PUR_RST;
			sel_reg  <= `TDPM_SEL_RST;
			dir_reg  <= `TDPM_GPIO_RST;
			gout_reg <= `TDPM_GPIO_RST;
		end else if (clk_en) begin
			wb_ack_o <= req & hit;
			wb_err_o <= req & ~hit;
			wb_dat_o <= (req & hit & ~wb_we_i) ? rdata_next : 32'h0000_0000;
			if (wr_lo & hit) begin
				case (adr)
				`TDPM_OFF_PUDR:
					pudr_reg <= wb_dat_i[`TDPM_PUDR_TEST_BIT];
				`TDPM_OFF_PUR:
					pur_reg <= wb_dat_i[7:0];
				`TDPM_OFF_SEL:
					sel_reg <= wb_dat_i[3:0];
				`TDPM_OFF_GPIO_DIR:
					dir_reg <= wb_dat_i[1:0];
				`TDPM_OFF_GPIO_OUT:
					gout_reg <= wb_dat_i[1:0];
				default:
					pudr_reg <= pudr_reg;
				endcase
			end
		end
	end

	// ***************************************************************
	// Pin input synchronisers
	// ***************************************************************
	// Phase pins resync to idle high; stage 0 feeds only stage 1
	always @(posedge mclk) begin
		if (sys_rst) begin
			a_sync_reg <= 2'h3;
			b_sync_reg <= 2'h3;
		end else if (clk_en) begin
			a_sync_reg <= {a_sync_reg[0], pin_a_in};
			b_sync_reg <= {b_sync_reg[0], pin_b_in};
		end
	end

	// ***************************************************************
	// Test reset path
	// ***************************************************************
	// Not cleared by device reset, so a low pin during device reset
	// still reaches the test controller; fills within three edges
	always @(posedge mclk) begin
		if (clk_en) begin
			trst_sync_reg <= {trst_sync_reg[0], test_rst_n_pin};
			test_rst_n    <= trst_s;
		end
	end

	// ***************************************************************
	// Pull-up control
	// ***************************************************************
	// Disable bit set turns the test pin pull-up off
	always @* begin
		test_rst_pullup_next = ~pudr_reg;
		pin_a_pullup_next    = pur_reg[`TDPM_PUR_A_BIT];
		pin_b_pullup_next    = pur_reg[`TDPM_PUR_B_BIT];
	end

	// ***************************************************************
	// Input steering
	// ***************************************************************
	// Only the selected function sees the pin; others see a quiet level
	always @* begin
		dec_a_next   = 1'b1;
		dec_b_next   = 1'b1;
		tmr0_in_next = 1'b0;
		tmr1_in_next = 1'b0;
		gpio_in_next = 2'h0;
		case (sel_a)
		`TDPM_FN_DECODER:
			dec_a_next = a_s;
		`TDPM_FN_TIMER:
			tmr0_in_next = a_s;
		`TDPM_FN_GPIO:
			gpio_in_next[`TDPM_GPIO_A_BIT] = a_s;
		default:
			dec_a_next = 1'b1;
		endcase
		case (sel_b)
		`TDPM_FN_DECODER:
			dec_b_next = b_s;
		`TDPM_FN_TIMER:
			tmr1_in_next = b_s;
		`TDPM_FN_GPIO:
			gpio_in_next[`TDPM_GPIO_B_BIT] = b_s;
		default:
			dec_b_next = 1'b1;
		endcase
	end

	// ***************************************************************
	// Pad drive steering
	// ***************************************************************
	// One owner drives each pad; decoder and spare codes leave it off
	always @* begin
		a_out_next = 1'b0;
		a_oe_next  = 1'b0;
		b_out_next = 1'b0;
		b_oe_next  = 1'b0;
		case (sel_a)
		`TDPM_FN_TIMER: begin
			a_out_next = timer_ch0_out;
			a_oe_next  = timer_ch0_oe;
		end
		`TDPM_FN_GPIO: begin
			a_out_next = gout_reg[`TDPM_GPIO_A_BIT];
			a_oe_next  = dir_reg[`TDPM_GPIO_A_BIT];
		end
		default: begin
			a_out_next = 1'b0;
			a_oe_next  = 1'b0;
		end
		endcase
		case (sel_b)
		`TDPM_FN_TIMER: begin
			b_out_next = timer_ch1_out;
			b_oe_next  = timer_ch1_oe;
		end
		`TDPM_FN_GPIO: begin
			b_out_next = gout_reg[`TDPM_GPIO_B_BIT];
			b_oe_next  = dir_reg[`TDPM_GPIO_B_BIT];
		end
		default: begin
			b_out_next = 1'b0;
			b_oe_next  = 1'b0;
		end
		endcase
	end

	// ***************************************************************
	// Output registers
	// ***************************************************************
	// Registered so pad and function levels change on clean edges
	always @(posedge mclk) begin
		if (sys_rst) begin
			test_rst_pullup_en <= 1'b1;
			pin_a_out          <= 1'b0;
			pin_a_oe           <= 1'b0;
			pin_b_out          <= 1'b0;
			pin_b_oe           <= 1'b0;
			pin_a_pullup_en    <= 1'b1;
			pin_b_pullup_en    <= 1'b1;
			decoder_phase_a_in <= 1'b1;
			decoder_phase_b_in <= 1'b1;
			timer_ch0_in       <= 1'b0;
			timer_ch1_in       <= 1'b0;
			port_c_in          <= 2'h0;
		end else if (clk_en) begin
			test_rst_pullup_en <= test_rst_pullup_next;
			pin_a_pullup_en    <= pin_a_pullup_next;
			pin_b_pullup_en    <= pin_b_pullup_next;
			decoder_phase_a_in <= dec_a_next;
			decoder_phase_b_in <= dec_b_next;
			timer_ch0_in       <= tmr0_in_next;
			timer_ch1_in       <= tmr1_in_next;
			port_c_in          <= gpio_in_next;
			pin_a_out          <= a_out_next;
			pin_a_oe           <= a_oe_next;
			pin_b_out          <= b_out_next;
			pin_b_oe           <= b_oe_next;
		end
	end

endmodule // tdpm_pin_mux

/* tb/tdpm_pin_mux_sva.sv */
// Assertion checker for the pin mux ports
`timescale 1ns/10ps
module tdpm_sva (
	input logic       mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_ack_o,
	input logic       wb_err_o, test_rst_n_pin, test_rst_n, pin_a_in,
	input logic       pin_b_in, pin_a_oe, test_rst_pullup_en, timer_ch0_in,
	input logic       pin_a_pullup_en, pin_b_pullup_en, decoder_phase_a_in,
	input logic       decoder_phase_b_in,
	input logic [1:0] port_c_in
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
		|=> wb_ack_o || wb_err_o; endproperty
	a_ack: assert property (p_ack) else $error("bus not answered");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_trst; test_rst_n == $past(test_rst_n_pin, 3); endproperty
	a_trst: assert property (p_trst) else $error("test reset lag");
	property p_deca; !decoder_phase_a_in |-> !$past(pin_a_in, 3); endproperty
	a_deca: assert property (p_deca) else $error("phase A path");
	property p_decb; !decoder_phase_b_in |-> !$past(pin_b_in, 3); endproperty
	a_decb: assert property (p_decb) else $error("phase B path");
	property p_one; $countones({!decoder_phase_a_in, timer_ch0_in,
		port_c_in[0]}) <= 1; endproperty
	a_one: assert property (p_one) else $error("two functions");
	property p_pu; $changed({test_rst_pullup_en, pin_a_pullup_en,
		pin_b_pullup_en}) |-> $past(wb_ack_o); endproperty
	a_pu: assert property (p_pu) else $error("pull-up moved");
	property p_rst; $fell(sys_rst) |-> pin_a_pullup_en && pin_b_pullup_en
		&& decoder_phase_a_in && !pin_a_oe; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_err: cover property (wb_err_o);
	c_dec: cover property (!decoder_phase_a_in);
	c_tmr: cover property (timer_ch0_in);
endmodule // tdpm_sva
bind tdpm_pin_mux tdpm_sva u_sva (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_err_o, .test_rst_n_pin, .test_rst_n, .pin_a_in, .pin_b_in,
	.pin_a_oe, .test_rst_pullup_en, .timer_ch0_in, .pin_a_pullup_en,
	.pin_b_pullup_en, .decoder_phase_a_in, .decoder_phase_b_in, .port_c_in);

/* tb/tdpm_probe.sv */
// Quadrature encoder and debug probe on the far side of the pins
`timescale 1ns/10ps
module tdpm_probe (
	input  wire mclk, step, dev_rst, keep_tap,
	input  wire a_oe, a_out, b_oe, b_out,
	output wire pin_a, pin_b, trst_n
);
	reg [1:0] cnt_reg = 2'h0;
	// One quadrature step per request
	always @(posedge mclk) if (step) cnt_reg <= cnt_reg + 2'h1;
	// Driving side wins, encoder otherwise
	assign pin_a = a_oe ? a_out : cnt_reg[1];
	assign pin_b = b_oe ? b_out : ^cnt_reg;
	// Test reset low with device reset unless port kept
	assign trst_n = !(dev_rst && !keep_tap);
endmodule // tdpm_probe

/* tb/tb_top.sv */
// Self-checking bench for the pin mux
`timescale 1ns/10ps
module tb_top;
	reg         mclk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, berr;
	reg         wb_stb_i = 1'b0, wb_we_i = 1'b0, step = 1'b0, keep = 1'b0;
	reg         timer_ch0_out = 1'b0, timer_ch0_oe = 1'b0, clk_en = 1'b1;
	reg  [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, rd;
	wire [31:0] wb_dat_o;
	wire [1:0]  port_c_in;
	wire        wb_ack_o, wb_err_o, test_rst_n_pin, test_rst_n, pin_a_in;
	wire        test_rst_pullup_en, pin_a_out, pin_a_oe, pin_a_pullup_en;
	wire        pin_b_in, pin_b_out, pin_b_oe, pin_b_pullup_en, timer_ch0_in;
	wire        decoder_phase_a_in, decoder_phase_b_in, timer_ch1_in;
	integer     failures = 0, tests_run = 0, ticks = 0;
	// Clock
	initial forever #2 mclk = ~mclk;
	tdpm_pin_mux u_dut (.mclk, .sys_rst, .clk_en, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o,
		.wb_err_o, .test_rst_n_pin, .test_rst_n, .test_rst_pullup_en,
		.pin_a_in, .pin_a_out, .pin_a_oe, .pin_a_pullup_en, .pin_b_in,
		.pin_b_out, .pin_b_oe, .pin_b_pullup_en, .decoder_phase_a_in,
		.decoder_phase_b_in, .timer_ch0_out, .timer_ch0_oe, .timer_ch0_in,
		.timer_ch1_out(step), .timer_ch1_oe(keep), .timer_ch1_in, .port_c_in);
	tdpm_probe u_probe (.mclk, .step, .dev_rst(sys_rst), .keep_tap(keep),
		.a_oe(pin_a_oe), .a_out(pin_a_out), .b_oe(pin_b_oe), .b_out(pin_b_out),
		.pin_a(pin_a_in), .pin_b(pin_b_in), .trst_n(test_rst_n_pin));
	task chk(input [63:0] n, input [31:0] s, e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("[FAIL] %0s exp %h got %h", n, e, s);
		end
	endtask
	task wb(input w, input [31:0] a, d);
		@(posedge mclk) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i}
			<= {2'h3, w, a, d};
		do @(posedge mclk); while (!wb_ack_o && !wb_err_o);
		rd = wb_dat_o;
		berr = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task wn(input integer k); repeat (k) @(posedge mclk); endtask
	task t_reset; // defaults, then encoder steps
		integer i;
		chk("pu", {pin_a_pullup_en, pin_b_pullup_en, pin_a_oe}, 3'h6);
		wb(0, 32'h8, 32'h0);
		chk("sel", rd, 32'h0);
		wb(0, 32'h4, 32'h0);
		chk("pur", rd, 32'hFF);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge mclk) step <= 1'b1;
			@(posedge mclk) step <= 1'b0;
			wn(4);
			chk("deca", decoder_phase_a_in, pin_a_in);
			chk("decb", decoder_phase_b_in, pin_b_in);
		end
	endtask
	task t_pull(input [31:0] a, d, input [2:0] e); // one pull-up off
		wb(1, a, d);
		wn(2);
		chk("pull", {test_rst_pullup_en, pin_a_pullup_en, pin_b_pullup_en}, e);
	endtask
	task t_rst(input k, e); // device reset, port kept or not
		@(posedge mclk) {keep, sys_rst} <= {k, 1'b1};
		wn(4);
		chk("trst", test_rst_n, e);
		@(posedge mclk) sys_rst <= 1'b0;
		wn(4);
		chk("trst", test_rst_n, 1'b1);
	endtask
	task t_mux; // GPIO out on A, then timer on A, then bad address
		wb(1, 32'h8, 32'hA);
		wb(1, 32'hC, 32'h1);
		wb(1, 32'h10, 32'h1);
		wn(5);
		chk("gpio", {pin_a_oe, pin_a_out, pin_b_oe, port_c_in[0]}, 4'hD);
		@(posedge mclk) {timer_ch0_oe, timer_ch0_out} <= 2'h3;
		wb(1, 32'h8, 32'h9);
		wn(5);
		chk("tmr", {pin_a_oe, timer_ch0_in, port_c_in[0]}, 3'h6);
		wb(0, 32'h18, 32'h0);
		chk("unmap", berr, 1'b1);
	endtask
	task t_more; // A idle, B timer, status read, clock enable freeze
		wb(1, 32'h8, 32'h7);
		@(posedge mclk) {keep, step} <= 2'h3;
		wn(5);
		chk("tmr1", {pin_b_oe, pin_b_out, timer_ch1_in, pin_a_oe,
			timer_ch0_in, decoder_phase_a_in, port_c_in}, 8'hE4);
		@(posedge mclk) {keep, step} <= 2'h0;
		wn(5);
		wb(0, 32'h14, 32'h0);
		chk("stat", rd, {29'h0, 1'b1, pin_b_in, pin_a_in});
		@(posedge mclk) clk_en <= 1'b0;
		@(posedge mclk) {keep, step} <= 2'h3;
		wn(3);
		chk("frz", {pin_b_oe, pin_b_out}, 2'h0);
		@(posedge mclk) clk_en <= 1'b1;
		wn(2);
		chk("run", {pin_b_oe, pin_b_out}, 2'h3);
		@(posedge mclk) {keep, step} <= 2'h0;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk) begin
		ticks = ticks + 1;
		if (ticks == 2000) begin
			failures = failures + 1;
			finish_test;
		end
	end
	// Main sequence
	initial begin
		wn(4);
		sys_rst <= 1'b0;
		wn(4);
		t_reset;
		t_pull(32'h4, 32'hEF, 3'h5);
		t_pull(32'h4, 32'hDF, 3'h6);
		t_pull(32'h0, 32'h1, 3'h2);
		t_rst(1'b1, 1'b1);
		t_rst(1'b0, 1'b0);
		t_mux;
		t_more;
		finish_test;
	end
endmodule // tb_top
